//--- core/nat_pkg.sv
// ----------------------------------------------------------------
// Nibble datapath constants
// ----------------------------------------------------------------
package nat_pkg;

   // Datapath widths
   localparam int NAT_NIB_W = 4;
   localparam int NAT_ROM_W = 10;
   localparam int NAT_TADDR_W = 7;
   localparam int NAT_PAGE_W = 3;

   // Field positions inside the fetched table word
   localparam int NAT_ROM_HI_MSB = 7;
   localparam int NAT_ROM_HI_LSB = 4;
   localparam int NAT_ROM_LO_MSB = 3;
   localparam int NAT_ROM_UP_MSB = 9;
   localparam int NAT_ROM_UP_LSB = 8;

   // Values after reset
   localparam logic [3:0] NAT_ACC_RST = 4'h0;
   localparam logic [3:0] NAT_B_RST = 4'h0;
   localparam logic [2:0] NAT_D_RST = 3'h0;
   localparam logic NAT_CARRY_RST = 1'b0;

   // Cycles from table request to returned word
   localparam int NAT_TABLE_LAT = 1;

   // Decoded operations
   typedef enum logic [3:0] {
      NAT_OP_NOP = 4'h0,
      NAT_OP_LOAD_IMM = 4'h1,
      NAT_OP_TABLE_READ = 4'h2,
      NAT_OP_ADD_MEM = 4'h3,
      NAT_OP_ADD_MEM_CARRY = 4'h4,
      NAT_OP_ADD_IMM = 4'h5,
      NAT_OP_AND_MEM = 4'h6,
      NAT_OP_OR_MEM = 4'h7,
      NAT_OP_SET_CARRY = 4'h8,
      NAT_OP_CLEAR_CARRY = 4'h9,
      NAT_OP_TEST_CARRY = 4'ha,
      NAT_OP_COMPL = 4'hb,
      NAT_OP_ROTATE = 4'hc,
      NAT_OP_BIT_SET = 4'hd,
      NAT_OP_BIT_CLEAR = 4'he,
      NAT_OP_BIT_TEST = 4'hf
   } nat_op_t;

   // Execution unit states
   typedef enum logic [0:0] {
      NAT_ST_IDLE = 1'b0,
      NAT_ST_TABLE = 1'b1
   } nat_state_t;

endpackage : nat_pkg

//--- core/nat_alu.sv
// Contract
// - Load immediate; consecutive loads after first skipped
// - Table word bits 7-4 to B, 3-0 A
// - Table address is D low bits then A
// - Upper flag: bits 9-8 to D, D top cleared
// - Table read holds one return stack stage
// - Memory add into A, carry untouched
// - Add with carry updates A and carry
// - Immediate add skips next when no overflow
// - A becomes A AND memory nibble
// - A becomes A OR memory nibble
// - Set carry to one only
// - Clear carry to zero only
// - Carry test skips next when carry zero
// - A becomes its bitwise inverse
// - Rotate carry and A right by one
// - Set indexed bit of memory nibble
// - Clear indexed bit of memory nibble
// - Bit test skips next when bit zero
`timescale 1ns/1ns

module nat_alu
   import nat_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Instruction issue
   input wire logic op_valid,
   input wire nat_op_t op_code,
   input wire logic [3:0] op_imm,
   output logic op_ready,
   output logic op_skipped,
   // Pointed data memory
   input wire logic [3:0] pointed_memory_nibble,
   output logic mem_we_q,
   output logic [3:0] mem_wdata_q,
   // Table read port
   input wire logic upper_table_transfer_flag,
   input wire logic [9:0] table_word,
   output logic table_req_q,
   output logic [6:0] table_addr_q,
   // Return stack stage claim
   output logic return_stack_claim_q,
   // Architectural state
   output logic [3:0] acc_q,
   output logic [3:0] b_q,
   output logic [2:0] table_page_bits_q,
   output logic carry_flag_q,
   output logic skip_q
);

   // ----------------------------------------------------------------
   // Issue and suppression
   // ----------------------------------------------------------------

   nat_state_t state_q; // Execution unit state
   logic prev_load_q; // Last taken op was an immediate load
   logic accept; // Op taken this cycle
   logic suppress; // Taken op does nothing
   logic exec; // Taken op runs
   logic [4:0] sum_mem; // Memory add with carry out
   logic [4:0] sum_mem_c; // Memory add plus carry
   logic [4:0] sum_imm; // Immediate add with carry out
   logic [3:0] bit_mask; // One-hot bit select

   // Ready only while no table read is in flight
   assign op_ready = (state_q == NAT_ST_IDLE);
   assign accept = op_valid && op_ready;
   // Pending skip, or a load directly after a load
   assign suppress = skip_q ||
      (op_code == NAT_OP_LOAD_IMM && prev_load_q);
   assign exec = accept && !suppress;
   // A suppressed op still uses its issue cycle
   assign op_skipped = accept && suppress;

   // Adders, carries kept in bit 4
   assign sum_mem = {1'b0, acc_q} + {1'b0, pointed_memory_nibble};
   assign sum_mem_c = sum_mem + {4'h0, carry_flag_q};
   assign sum_imm = {1'b0, acc_q} + {1'b0, op_imm};
   assign bit_mask = 4'h1 << op_imm[1:0];

   // Track back-to-back immediate loads, executed or not
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_load_q <= 1'b0;
      end else if (accept) begin
         prev_load_q <= (op_code == NAT_OP_LOAD_IMM);
      end
   end

   // ----------------------------------------------------------------
   // Skip flag
   // ----------------------------------------------------------------

   // Set by a test op or an immediate add, consumed by the next taken op
   always_ff @(posedge clock) begin
      if (reset) begin
         skip_q <= 1'b0;
      end else if (accept) begin
         if (!exec) begin
            // Suppressed op consumes the skip
            skip_q <= 1'b0;
         end else begin
            case (op_code)
               NAT_OP_ADD_IMM: skip_q <= !sum_imm[4];
               NAT_OP_TEST_CARRY: skip_q <= !carry_flag_q;
               NAT_OP_BIT_TEST: begin
                  // Skip on a zero bit
                  skip_q <=
                     !pointed_memory_nibble[op_imm[1:0]];
               end
               default: skip_q <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Table read sequencer
   // ----------------------------------------------------------------

   // Idle, or waiting for the table word
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= NAT_ST_IDLE;
      end else begin
         case (state_q)
            NAT_ST_IDLE: begin
               if (exec && op_code == NAT_OP_TABLE_READ) begin
                  state_q <= NAT_ST_TABLE;
               end
            end
            NAT_ST_TABLE: state_q <= NAT_ST_IDLE;
            default: state_q <= NAT_ST_IDLE;
         endcase
      end
   end

   // Request pulse with the in-page address
   always_ff @(posedge clock) begin
      if (reset) begin
         table_req_q <= 1'b0;
         table_addr_q <= 7'h00;
      end else begin
         table_req_q <= exec && op_code == NAT_OP_TABLE_READ;
         if (exec && op_code == NAT_OP_TABLE_READ) begin
            // D low bits high, accumulator low
            table_addr_q <= {table_page_bits_q, acc_q};
         end
      end
   end

   // One stack stage held for the whole read
   always_ff @(posedge clock) begin
      if (reset) begin
         return_stack_claim_q <= 1'b0;
      end else if (exec && op_code == NAT_OP_TABLE_READ) begin
         return_stack_claim_q <= 1'b1;
      end else if (state_q == NAT_ST_TABLE) begin
         return_stack_claim_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------

   // Written by loads, arithmetic, logic and table reads
   always_ff @(posedge clock) begin
      if (reset) begin
         acc_q <= NAT_ACC_RST;
      end else if (state_q == NAT_ST_TABLE) begin
         acc_q <= table_word[NAT_ROM_LO_MSB:0];
      end else if (exec) begin
         case (op_code)
            NAT_OP_LOAD_IMM: acc_q <= op_imm;
            NAT_OP_ADD_MEM: acc_q <= sum_mem[3:0];
            NAT_OP_ADD_MEM_CARRY: acc_q <= sum_mem_c[3:0];
            NAT_OP_ADD_IMM: acc_q <= sum_imm[3:0];
            NAT_OP_AND_MEM: begin
               acc_q <= acc_q & pointed_memory_nibble;
            end
            NAT_OP_OR_MEM: begin
               acc_q <= acc_q | pointed_memory_nibble;
            end
            NAT_OP_COMPL: acc_q <= ~acc_q;
            NAT_OP_ROTATE: begin
               acc_q <= {carry_flag_q, acc_q[3:1]};
            end
            default: acc_q <= acc_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Carry flag
   // ----------------------------------------------------------------

   // Only add-with-carry, rotate, set and clear touch it
   always_ff @(posedge clock) begin
      if (reset) begin
         carry_flag_q <= NAT_CARRY_RST;
      end else if (exec) begin
         case (op_code)
            NAT_OP_ADD_MEM_CARRY: begin
               carry_flag_q <= sum_mem_c[4];
            end
            NAT_OP_SET_CARRY: carry_flag_q <= 1'b1;
            NAT_OP_CLEAR_CARRY: carry_flag_q <= 1'b0;
            NAT_OP_ROTATE: carry_flag_q <= acc_q[0];
            default: carry_flag_q <= carry_flag_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers B and D
   // ----------------------------------------------------------------

   // Upper table nibble lands in B
   always_ff @(posedge clock) begin
      if (reset) begin
         b_q <= NAT_B_RST;
      end else if (state_q == NAT_ST_TABLE) begin
         b_q <= table_word[NAT_ROM_HI_MSB:NAT_ROM_HI_LSB];
      end
   end

   // Top two word bits into D when the upper flag is set
   always_ff @(posedge clock) begin
      if (reset) begin
         table_page_bits_q <= NAT_D_RST;
      end else if (state_q == NAT_ST_TABLE && upper_table_transfer_flag) begin
         table_page_bits_q <=
            {1'b0, table_word[NAT_ROM_UP_MSB:NAT_ROM_UP_LSB]};
      end
   end

   // ----------------------------------------------------------------
   // Memory bit write-back
   // ----------------------------------------------------------------

   // Write strobe one cycle after a bit set or clear
   always_ff @(posedge clock) begin
      if (reset) begin
         mem_we_q <= 1'b0;
         mem_wdata_q <= 4'h0;
      end else begin
         mem_we_q <= exec &&
            (op_code == NAT_OP_BIT_SET || op_code == NAT_OP_BIT_CLEAR);
         if (exec && op_code == NAT_OP_BIT_SET) begin
            mem_wdata_q <= pointed_memory_nibble | bit_mask;
         end else if (exec && op_code == NAT_OP_BIT_CLEAR) begin
            mem_wdata_q <= pointed_memory_nibble & ~bit_mask;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   default clocking chk_cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // Helper conditions
   logic ex_tab;
   logic ex_addm;
   logic ex_adc;
   logic ex_addi;
   assign ex_tab = exec && op_code == NAT_OP_TABLE_READ;
   assign ex_addm = exec && op_code == NAT_OP_ADD_MEM;
   assign ex_adc = exec && op_code == NAT_OP_ADD_MEM_CARRY;
   assign ex_addi = exec && op_code == NAT_OP_ADD_IMM;

   // Table read: request then word capture
   sequence tab_issue_s;
      ex_tab;
   endsequence
   sequence tab_fetch_s;
      table_req_q && return_stack_claim_q && !op_ready;
   endsequence

   load_skip_a: assert property (accept && op_code == NAT_OP_LOAD_IMM &&
      prev_load_q |=> acc_q == $past(acc_q))
      else $error("consecutive load changed accumulator");
   table_seq_a: assert property (tab_issue_s ##1 tab_fetch_s |=>
      acc_q == $past(table_word[3:0]) && b_q == $past(table_word[7:4])
      && op_ready)
      else $error("table word not split into B and A");
   table_addr_a: assert property (tab_issue_s |=> table_addr_q ==
      {$past(table_page_bits_q), $past(acc_q)})
      else $error("table address wrong");
   table_upper_a: assert property (tab_issue_s ##1 upper_table_transfer_flag
      |=> table_page_bits_q == {1'b0, $past(table_word[9:8])})
      else $error("upper bits not moved into D");
   stack_hold_a: assert property (tab_issue_s |=>
      return_stack_claim_q ##1 !return_stack_claim_q)
      else $error("stack stage not held for table read");
   add_mem_a: assert property (ex_addm |=> $stable(carry_flag_q) &&
      acc_q == $past(acc_q) + $past(pointed_memory_nibble))
      else $error("memory add wrong");
   add_carry_a: assert property (ex_adc |=>
      {carry_flag_q, acc_q} == $past(acc_q) + $past(pointed_memory_nibble)
      + $past(carry_flag_q))
      else $error("add with carry wrong");
   add_imm_a: assert property (ex_addi |=> $stable(carry_flag_q) &&
      skip_q == ($past(acc_q) + $past(op_imm) < 5'h10))
      else $error("immediate add skip wrong");
   logic_and_a: assert property (exec && op_code == NAT_OP_AND_MEM |=>
      acc_q == ($past(acc_q) & $past(pointed_memory_nibble)))
      else $error("AND result wrong");
   logic_or_a: assert property (exec && op_code == NAT_OP_OR_MEM |=>
      acc_q == ($past(acc_q) | $past(pointed_memory_nibble)))
      else $error("OR result wrong");
   set_carry_a: assert property (exec && op_code == NAT_OP_SET_CARRY |=>
      carry_flag_q && acc_q == $past(acc_q))
      else $error("set carry wrong");
   clear_carry_a: assert property (exec && op_code == NAT_OP_CLEAR_CARRY
      |=> !carry_flag_q && acc_q == $past(acc_q))
      else $error("clear carry wrong");
   carry_test_a: assert property (exec && op_code == NAT_OP_TEST_CARRY |=>
      skip_q == !carry_flag_q && $stable(carry_flag_q))
      else $error("carry test wrong");
   compl_a: assert property (exec && op_code == NAT_OP_COMPL |=>
      acc_q == ~$past(acc_q))
      else $error("complement wrong");
   rotate_a: assert property (exec && op_code == NAT_OP_ROTATE |=>
      {acc_q, carry_flag_q} ==
      {$past(carry_flag_q), $past(acc_q)})
      else $error("rotate wrong");
   bit_write_a: assert property (exec && op_code == NAT_OP_BIT_SET |=>
      mem_we_q && mem_wdata_q[$past(op_imm[1:0])])
      else $error("bit set wrong");
   bit_clear_a: assert property (exec && op_code == NAT_OP_BIT_CLEAR |=>
      mem_we_q && !mem_wdata_q[$past(op_imm[1:0])])
      else $error("bit clear wrong");
   bit_test_a: assert property (exec && op_code == NAT_OP_BIT_TEST |=>
      skip_q == !$past(pointed_memory_nibble[op_imm[1:0]]))
      else $error("bit test skip wrong");
   skip_quiet_a: assert property (op_skipped |=> $stable(acc_q) &&
      $stable(carry_flag_q) && $stable(b_q) && !mem_we_q && !table_req_q &&
      !skip_q)
      else $error("suppressed op had an effect");

endmodule : nat_alu

//--- test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import nat_pkg::*;
   // ----------------------------------------------------------------
   // Expected result of one taken op
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] b;
      logic [2:0] d;
      logic cy;
      logic skip;
      logic skipped;
      logic we;
      logic [3:0] wdata;
   } nat_note_t;
   // Design ports
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic op_valid = 1'b0;
   nat_op_t op_code = NAT_OP_NOP;
   logic [3:0] op_imm = 4'h0;
   logic [3:0] mem_nib = 4'h0;
   logic up_flag = 1'b0;
   logic [9:0] table_word = 10'h000;
   logic op_ready, op_skipped, mem_we_q, table_req_q, claim_q;
   logic [3:0] mem_wdata_q, acc_q, b_q;
   logic [6:0] table_addr_q;
   logic [2:0] d_q;
   logic cy_q, skip_q;
   // Reference state and bookkeeping
   logic [3:0] m_acc = 4'h0;
   logic [3:0] m_b = 4'h0;
   logic [2:0] m_d = 3'h0;
   logic m_cy = 1'b0;
   logic m_skip = 1'b0;
   logic m_last = 1'b0;
   logic fire = 1'b0;
   logic seen_sk = 1'b0;
   nat_note_t notes[$];
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] r;

   nat_alu dut_u (.clock(clock), .reset(reset), .op_valid(op_valid),
      .op_code(op_code), .op_imm(op_imm), .op_ready(op_ready),
      .op_skipped(op_skipped), .pointed_memory_nibble(mem_nib),
      .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
      .upper_table_transfer_flag(up_flag), .table_word(table_word),
      .table_req_q(table_req_q), .table_addr_q(table_addr_q),
      .return_stack_claim_q(claim_q), .acc_q(acc_q), .b_q(b_q),
      .table_page_bits_q(d_q), .carry_flag_q(cy_q), .skip_q(skip_q));

   // 40 ns clock
   initial begin
      forever #20 clock = ~clock;
   end

   // Compare one value
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Verdict and end of run
   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // Offer one op, note its expected outcome, serve a table wait
   task automatic do_op(input nat_op_t op, input logic [3:0] imm,
         input logic [3:0] mem, input logic upf, input logic [9:0] w);
      nat_note_t n;
      logic [4:0] s;
      logic sup;
      logic [6:0] a;
      n = '0;
      a = {m_d, m_acc};
      sup = m_skip || (op == NAT_OP_LOAD_IMM && m_last);
      n.skipped = sup;
      m_last = (op == NAT_OP_LOAD_IMM);
      if (sup) begin
         m_skip = 1'b0;
      end else begin
         case (op)
            NAT_OP_LOAD_IMM: m_acc = imm;
            NAT_OP_TABLE_READ: begin
               {m_b, m_acc} = w[7:0];
               if (upf) begin
                  m_d = {1'b0, w[9:8]};
               end
            end
            NAT_OP_ADD_MEM: m_acc = m_acc + mem;
            NAT_OP_ADD_MEM_CARRY: {m_cy, m_acc} = m_acc + mem + m_cy;
            NAT_OP_ADD_IMM: begin
               s = m_acc + imm;
               m_acc = s[3:0];
               m_skip = !s[4];
            end
            NAT_OP_AND_MEM: m_acc = m_acc & mem;
            NAT_OP_OR_MEM: m_acc = m_acc | mem;
            NAT_OP_SET_CARRY: m_cy = 1'b1;
            NAT_OP_CLEAR_CARRY: m_cy = 1'b0;
            NAT_OP_TEST_CARRY: m_skip = !m_cy;
            NAT_OP_COMPL: m_acc = ~m_acc;
            NAT_OP_ROTATE: {m_acc, m_cy} = {m_cy, m_acc};
            NAT_OP_BIT_SET: n.wdata = mem | (4'h1 << imm[1:0]);
            NAT_OP_BIT_CLEAR: n.wdata = mem & ~(4'h1 << imm[1:0]);
            NAT_OP_BIT_TEST: m_skip = !mem[imm[1:0]];
            default: ;
         endcase
         n.we = (op == NAT_OP_BIT_SET || op == NAT_OP_BIT_CLEAR);
      end
      n.acc = m_acc;
      n.b = m_b;
      n.d = m_d;
      n.cy = m_cy;
      n.skip = m_skip;
      notes.push_back(n);
      op_valid = 1'b1;
      op_code = op;
      op_imm = imm;
      mem_nib = mem;
      @(negedge clock);
      if (op == NAT_OP_TABLE_READ && !sup) begin
         check(table_req_q, 10'h001);
         check(table_addr_q, a);
         check(claim_q, 10'h001);
         check(op_ready, 10'h000);
         op_valid = 1'b0;
         up_flag = upf;
         table_word = w;
         @(negedge clock);
         table_word = ~w;
      end
   endtask : do_op

   // Mark edges at which a result lands; a suppressed table read
   // ends at once, an executed one an edge after its request edge
   always @(posedge clock) begin
      fire <= !reset && (table_req_q || (op_valid && op_ready &&
         (op_code != NAT_OP_TABLE_READ || op_skipped)));
      seen_sk <= op_valid && op_ready && op_skipped;
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Compare settled outputs with the oldest note
   always @(negedge clock) begin
      nat_note_t n;
      if (fire) begin
         if (notes.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] %0t result with no note", $time);
         end else begin
            n = notes.pop_front();
            check(acc_q, n.acc);
            check(b_q, n.b);
            check(d_q, n.d);
            check(cy_q, n.cy);
            check(skip_q, n.skip);
            check(seen_sk, n.skipped);
            check(mem_we_q, n.we);
            check(claim_q, 10'h000);
            if (n.we) begin
               check(mem_wdata_q, n.wdata);
            end
         end
      end
   end

   // Reset, directed runs, then random ops
   initial begin
      repeat (5) @(negedge clock);
      reset = 1'b0;
      check({acc_q, b_q, cy_q, skip_q}, 10'h000);
      check(10'({d_q, op_ready}), 10'h001);
      r = $urandom(32'h6471);
      do_op(NAT_OP_LOAD_IMM, 4'h5, 4'h0, 1'b0, 10'h000);
      do_op(NAT_OP_LOAD_IMM, 4'h9, 4'h0, 1'b0, 10'h000);
      do_op(NAT_OP_LOAD_IMM, 4'ha, 4'h0, 1'b0, 10'h000);
      do_op(NAT_OP_TABLE_READ, 4'h0, 4'h0, 1'b1, 10'h2c7);
      do_op(NAT_OP_TABLE_READ, 4'h0, 4'h0, 1'b0, 10'h13a);
      do_op(NAT_OP_ADD_IMM, 4'hf, 4'h0, 1'b0, 10'h000);
      do_op(NAT_OP_TEST_CARRY, 4'h0, 4'h0, 1'b0, 10'h000);
      for (int k = 0; k < 16; k++) begin
         do_op(nat_op_t'(k), 4'h3, 4'h6, 1'b1, 10'h1e4);
      end
      // Mid-run reset clears the registers and any pending skip
      op_valid = 1'b0;
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      check({acc_q, b_q, cy_q, skip_q}, 10'h000);
      check(10'({d_q, op_ready}), 10'h001);
      {m_acc, m_b, m_d, m_cy, m_skip, m_last} = '0;
      for (int k = 0; k < 600; k++) begin
         r = $urandom;
         do_op(nat_op_t'(r[3:0]), r[7:4], r[11:8], r[12], r[31:22]);
      end
      op_valid = 1'b0;
      repeat (3) @(negedge clock);
      check(10'(notes.size()), 10'h000);
      finish_test();
   end
endmodule : tb_top
